// file: core/stop_recovery_and_watchdog.sv
// Stop-mode recovery control, clock divide chain and watchdog timer
//
// What this block does
// - Recovery register write-only except read-only flag
// - Flag set by recovery, cleared at power-on
// - Bit 6 picks recovery source active level
// - Bit 5 enables post-recovery reset delay
// - Bits 4..2 pick the recovery source
// - Bit 1 picks crystal divide-by-two or one
// - Bit 0 inserts divide-by-16 prescaler
// - Recovery register decoded at index 0BH
// - Watchdog is retriggerable one-shot resetting device
// - First refresh starts watchdog; never stops
// - Refresh also updates zero, sign, overflow
// - Mode bits 1..0 select timeout tap
// - Mode bit 2 keeps counting in HALT
// - Mode bit 3 keeps counting in STOP
// - Bits 3,4 set: crystal clocks watchdog only
// - Mode bit 4 picks crystal or RC
// - Mode bits 7..5 reserved, no function
// - Mode writable only 64 cycles after reset
// - Mode register write-only at index 0FH
// - Reset held while supply comparator reports low
// - STOP ends only by reset, restart 000CH
`timescale 1ns/1ps
`default_nettype none

module stop_recovery_and_watchdog
	import stop_wdt_pkg::*;
#(
	parameter int unsigned RST_DELAY_CYCLES = 1024,
	parameter int unsigned REC_SRC_W        = 8
)
(
	input  wire logic                  sys_clk_i,
	input  wire logic                  rstn_i,
	input  wire stop_wdt_pkg::apb_req_t apb_req_i,
	output      stop_wdt_pkg::apb_rsp_t apb_rsp_o,
	input  wire logic                  xtal_i,
	input  wire logic                  rcosc_i,
	input  wire logic                  supply_ok_i,
	input  wire logic [REC_SRC_W-1:0]  rec_src_i,
	input  wire logic                  spi_compare_i,
	input  wire logic                  wdt_exec_i,
	input  wire logic                  halt_req_i,
	input  wire logic                  stop_req_i,
	input  wire logic                  wake_i,
	output logic                       sclk_tick_o,
	output logic                       timer_clock_tick_o,
	output logic                       core_rst_o,
	output logic [15:0]                restart_vector_o,
	output logic                       flag_we_o,
	output logic [2:0]                 flags_zsv_o,
	output logic [2:0]                 pwr_state_o
);
	import stop_wdt_pkg::*;

	localparam int unsigned SYNC_W = REC_SRC_W + 3;
	localparam logic [15:0] RST_DELAY = 16'(RST_DELAY_CYCLES);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] async_in;
	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	logic              xtal_d_r;
	logic              rc_d_r;
	logic              xt_tick;
	logic              rc_tick;
	logic              supply_low;
	logic [REC_SRC_W-1:0] rec_sync;

	logic [6:0]  src_ctl_r;
	logic        rec_flag_r;
	logic [4:0]  wdm_r;
	logic [6:0]  win_cnt_r;
	logic        win_open;

	logic        div2_r;
	logic [3:0]  pre_cnt_r;
	logic        base_tick;
	logic        pre_tick;

	pwr_state_t  state_r;
	logic        rst_active_r;
	logic [15:0] rst_cnt_r;
	logic [1:0]  cause_r;
	logic        recover;
	logic        rec_level;
	logic [2:0]  rec_sel;

	logic        wdt_run_r;
	logic [12:0] wdt_cnt_r;
	logic        wdt_to_r;
	logic        wdt_tick;
	logic        wdt_gate;
	logic [12:0] tap_last;
	logic        exec;

	logic        access;
	logic        setup;
	logic        wr_acc;
	logic        mapped;
	logic [DATA_W-1:0] prdata_r;

	// Word-aligned hit on a register index
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		return a == {2'b00, idx, 2'b00};
	endfunction

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// Pins and oscillator outputs are asynchronous to sys_clk_i
	assign async_in = {rec_src_i, supply_ok_i, rcosc_i, xtal_i};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++)
		begin : g_sync
			always_ff @(posedge sys_clk_i or negedge rstn_i)
			begin
				if (!rstn_i)
				begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
				end
				else
				begin
					sync1_r[gi] <= async_in[gi];
					sync2_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate

	// Edge history taken from the second stage only
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			xtal_d_r <= 1'b0;
			rc_d_r   <= 1'b0;
		end
		else
		begin
			xtal_d_r <= sync2_r[0];
			rc_d_r   <= sync2_r[1];
		end
	end

	// Oscillators must run well below sys_clk_i / 4 to be seen
	assign xt_tick    = sync2_r[0] & ~xtal_d_r;
	assign rc_tick    = sync2_r[1] & ~rc_d_r;
	assign supply_low = ~sync2_r[2];
	assign rec_sync   = sync2_r[SYNC_W-1:3];

	// ----------------------------------------------------------------
	// Device reset sequencer
	// ----------------------------------------------------------------
	assign rec_sel   = src_ctl_r[SRC_SEL_MSB:SRC_SEL_LSB];
	assign rec_level = src_ctl_r[SRC_LEVEL_BIT] ? rec_sync[rec_sel] : ~rec_sync[rec_sel];
	assign recover   = (state_r == PWR_STOP) && !rst_active_r
		&& (((rec_sel != SRC_SEL_NONE) && rec_level) || spi_compare_i);

	// Priority: supply, then watchdog, then stop recovery
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rst_active_r <= 1'b1;
			rst_cnt_r    <= RST_DELAY;
			cause_r      <= CAUSE_POR;
		end
		else if (supply_low)
		begin
			rst_active_r <= 1'b1;
			rst_cnt_r    <= RST_DELAY;
			cause_r      <= CAUSE_SUPPLY;
		end
		else if (wdt_to_r)
		begin
			rst_active_r <= 1'b1;
			rst_cnt_r    <= RST_DELAY;
			cause_r      <= CAUSE_WDT;
		end
		else if (recover)
		begin
			rst_active_r <= 1'b1;
			rst_cnt_r    <= src_ctl_r[SRC_DELAY_BIT] ? RST_DELAY : SHORT_RST;
			cause_r      <= CAUSE_RECOV;
		end
		else if (rst_active_r)
		begin
			if (rst_cnt_r == 16'h0000)
				rst_active_r <= 1'b0;
			else
				rst_cnt_r <= rst_cnt_r - 16'h0001;
		end
	end

	// Vector is fixed; held in a flop so the output is registered
	// Restart vector
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			restart_vector_o <= RESTART_VECTOR;
		else
			restart_vector_o <= RESTART_VECTOR;
	end

	assign core_rst_o = rst_active_r;

	// ----------------------------------------------------------------
	// Power state
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			state_r <= PWR_RUN;
		else if (rst_active_r)
			state_r <= PWR_RUN;
		else
		begin
			case (state_r)
				PWR_RUN:
				begin
					if (stop_req_i)
						state_r <= PWR_STOP;
					else if (halt_req_i)
						state_r <= PWR_HALT;
				end
				PWR_HALT:
				begin
					if (wake_i)
						state_r <= PWR_RUN;
				end
				PWR_STOP:
					state_r <= PWR_STOP;
				default:
					state_r <= PWR_RUN;
			endcase
		end
	end

	assign pwr_state_o = state_r;

	// ----------------------------------------------------------------
	// System and timer clock chain
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			div2_r    <= 1'b0;
			pre_cnt_r <= 4'h0;
		end
		else
		begin
			if (xt_tick)
				div2_r <= ~div2_r;
			if (base_tick)
				pre_cnt_r <= pre_cnt_r + 4'h1;
		end
	end

	assign base_tick = src_ctl_r[SRC_DIV1_BIT] ? xt_tick : (xt_tick & div2_r);
	assign pre_tick  = src_ctl_r[SRC_PRE16_BIT] ? (base_tick && pre_cnt_r == PRE16_LAST)
		: base_tick;

	// System clock stops in HALT; both stop in STOP and under reset
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sclk_tick_o <= 1'b0;
			timer_clock_tick_o <= 1'b0;
		end
		else
		begin
			sclk_tick_o <= pre_tick && state_r == PWR_RUN && !rst_active_r;
			timer_clock_tick_o <= pre_tick && state_r != PWR_STOP && !rst_active_r;
		end
	end

	// ----------------------------------------------------------------
	// Recovery register and flag
	// ----------------------------------------------------------------
	// Control bits return to default on every device reset
	// Write-only control bits
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			src_ctl_r <= SRC_RESET;
		else if (rst_active_r)
			src_ctl_r <= SRC_RESET;
		else if (wr_acc && reg_hit(apb_req_i.paddr, IDX_STOP_REC))
			src_ctl_r <= apb_req_i.pwdata[6:0];
	end

	// Only a power-on cycle clears it; nothing else races the set
	// Hardware recovery flag
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rec_flag_r <= 1'b0;
		else if (recover)
			rec_flag_r <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Watchdog mode register and its write window
	// ----------------------------------------------------------------
	assign win_open = win_cnt_r < WINDOW_CYCLES;

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			win_cnt_r <= 7'h00;
		else if (rst_active_r)
			win_cnt_r <= 7'h00;
		else if (sclk_tick_o && win_open)
			win_cnt_r <= win_cnt_r + 7'h01;
	end

	// Late writes are acknowledged but change nothing
	// Discard late writes
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			wdm_r <= WDM_RESET;
		else if (rst_active_r)
			wdm_r <= WDM_RESET;
		else if (wr_acc && win_open && reg_hit(apb_req_i.paddr, IDX_WDT_MODE))
			wdm_r <= apb_req_i.pwdata[4:0];
	end

	// ----------------------------------------------------------------
	// Watchdog counter
	// ----------------------------------------------------------------
	// Timeout tap select
	always_comb
	begin
		case (wdm_r[WDM_TAP_MSB:WDM_TAP_LSB])
			2'h0:    tap_last = TAP0_LAST;
			2'h1:    tap_last = TAP1_LAST;
			2'h2:    tap_last = TAP2_LAST;
			default: tap_last = TAP3_LAST;
		endcase
	end

	assign wdt_tick = wdm_r[WDM_XTAL_BIT] ? xt_tick : rc_tick;

	always_comb
	begin
		case (state_r)
			PWR_HALT: wdt_gate = wdm_r[WDM_HALT_BIT];
			PWR_STOP: wdt_gate = wdm_r[WDM_STOP_BIT];
			default:  wdt_gate = 1'b1;
		endcase
	end

	// Refresh from the core or the command register, only when running
	assign exec = !rst_active_r && state_r == PWR_RUN && (wdt_exec_i
		|| (wr_acc && reg_hit(apb_req_i.paddr, IDX_WDT_CMD)
		&& apb_req_i.pwdata[CMD_EXEC_BIT]));

	// Run flag survives device resets so the watchdog cannot be stopped
	// Start and retrigger
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			wdt_run_r <= 1'b0;
		else if (exec)
			wdt_run_r <= 1'b1;
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			wdt_cnt_r <= 13'h0000;
			wdt_to_r  <= 1'b0;
		end
		else if (rst_active_r || exec)
		begin
			wdt_cnt_r <= 13'h0000;
			wdt_to_r  <= 1'b0;
		end
		else if (wdt_run_r && wdt_tick && wdt_gate)
		begin
			if (wdt_cnt_r >= tap_last)
			begin
				wdt_cnt_r <= 13'h0000;
				wdt_to_r  <= 1'b1;
			end
			else
			begin
				wdt_cnt_r <= wdt_cnt_r + 13'h0001;
				wdt_to_r  <= 1'b0;
			end
		end
		else
			wdt_to_r <= 1'b0;
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			flag_we_o   <= 1'b0;
			flags_zsv_o <= 3'h0;
		end
		else
		begin
			flag_we_o <= exec;
			if (exec)
				flags_zsv_o <= WDT_FLAGS_ZSV;
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	assign setup  = apb_req_i.psel && !apb_req_i.penable;
	assign access = apb_req_i.psel && apb_req_i.penable;
	assign wr_acc = access && apb_req_i.pwrite;
	assign mapped = reg_hit(apb_req_i.paddr, IDX_STOP_REC)
		|| reg_hit(apb_req_i.paddr, IDX_WDT_MODE)
		|| reg_hit(apb_req_i.paddr, IDX_WDT_CMD)
		|| reg_hit(apb_req_i.paddr, IDX_STATUS);

	// Read data captured in setup so the access phase needs no wait
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			prdata_r <= '0;
		else if (setup)
		begin
			prdata_r <= '0;
			if (reg_hit(apb_req_i.paddr, IDX_STOP_REC))
				prdata_r[SRC_FLAG_BIT] <= rec_flag_r;
			else if (reg_hit(apb_req_i.paddr, IDX_STATUS))
				prdata_r[8:0] <= {cause_r, rst_active_r, rec_flag_r, win_open,
					wdt_run_r, state_r};
		end
	end

	assign apb_rsp_o.pready  = 1'b1;
	assign apb_rsp_o.pslverr = access && !mapped;
	assign apb_rsp_o.prdata  = prdata_r;

endmodule

`default_nettype wire

// file: core/stop_wdt_pkg.sv
// Constants, types and register map for the stop recovery and watchdog block
package stop_wdt_pkg;

	// ----------------------------------------------------------------
	// Bus shape
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_STOP_REC = 8'h0B;
	localparam logic [7:0] IDX_WDT_MODE = 8'h0F;
	localparam logic [7:0] IDX_WDT_CMD  = 8'h10;
	localparam logic [7:0] IDX_STATUS   = 8'h11;

	// ----------------------------------------------------------------
	// stop_recovery_control fields
	// ----------------------------------------------------------------
	localparam int unsigned SRC_FLAG_BIT  = 7;
	localparam int unsigned SRC_LEVEL_BIT = 6;
	localparam int unsigned SRC_DELAY_BIT = 5;
	localparam int unsigned SRC_SEL_MSB   = 4;
	localparam int unsigned SRC_SEL_LSB   = 2;
	localparam int unsigned SRC_DIV1_BIT  = 1;
	localparam int unsigned SRC_PRE16_BIT = 0;
	localparam logic [6:0]  SRC_RESET     = 7'h00;
	localparam logic [2:0]  SRC_SEL_NONE  = 3'h0;

	// ----------------------------------------------------------------
	// watchdog_mode_control fields
	// ----------------------------------------------------------------
	localparam int unsigned WDM_TAP_MSB  = 1;
	localparam int unsigned WDM_TAP_LSB  = 0;
	localparam int unsigned WDM_HALT_BIT = 2;
	localparam int unsigned WDM_STOP_BIT = 3;
	localparam int unsigned WDM_XTAL_BIT = 4;
	localparam logic [4:0]  WDM_RESET    = 5'h0D;

	// Timeout taps in watchdog clock periods, minus one
	localparam logic [12:0] TAP0_LAST = 13'h00FF;
	localparam logic [12:0] TAP1_LAST = 13'h01FF;
	localparam logic [12:0] TAP2_LAST = 13'h03FF;
	localparam logic [12:0] TAP3_LAST = 13'h0FFF;

	// ----------------------------------------------------------------
	// Command, status and timing
	// ----------------------------------------------------------------
	localparam int unsigned CMD_EXEC_BIT   = 0;
	localparam logic [6:0]  WINDOW_CYCLES  = 7'h40;
	localparam logic [3:0]  PRE16_LAST     = 4'hF;
	localparam logic [15:0] RESTART_VECTOR = 16'h000C;
	localparam logic [15:0] SHORT_RST      = 16'h0001;
	localparam logic [2:0]  WDT_FLAGS_ZSV  = 3'h0;

	// Last reset cause codes
	localparam logic [1:0] CAUSE_POR    = 2'h0;
	localparam logic [1:0] CAUSE_SUPPLY = 2'h1;
	localparam logic [1:0] CAUSE_WDT    = 2'h2;
	localparam logic [1:0] CAUSE_RECOV  = 2'h3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PWR_RUN  = 3'b001,
		PWR_HALT = 3'b010,
		PWR_STOP = 3'b100
	} pwr_state_t;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic              pready;
		logic              pslverr;
		logic [DATA_W-1:0] prdata;
	} apb_rsp_t;

endpackage

// file: sim/stop_recovery_and_watchdog_bench.sv
// Self-checking bench for the stop recovery and watchdog block
`timescale 1ns/1ps
`default_nettype none

module stop_recovery_and_watchdog_bench;
	import stop_wdt_pkg::*;
	// ------------------------------------------------------------
	// Signals and map
	// ------------------------------------------------------------
	localparam logic [11:0] A_REC  = {2'b00, IDX_STOP_REC, 2'b00};
	localparam logic [11:0] A_MODE = {2'b00, IDX_WDT_MODE, 2'b00};
	localparam logic [11:0] A_STAT = {2'b00, IDX_STATUS, 2'b00};
	logic        sys_clk;
	logic        rstn;
	apb_req_t    req;
	apb_rsp_t    rsp;
	logic        supply_ok;
	logic [7:0]  rec_src;
	logic        wdt_exec;
	logic        stop_req;
	logic        halt_req;
	logic        wake;
	logic        sclk_tick;
	logic        timer_clock_tick;
	logic        core_rst;
	logic        flag_we;
	logic [2:0]  state;
	logic [3:0]  osc_cnt = 4'h0;
	logic [31:0] rd;
	logic        err;
	int          err_count;
	int          check_count;
	int          n;
	int          s;
	int          t;

	stop_recovery_and_watchdog #(.RST_DELAY_CYCLES(8), .REC_SRC_W(8))
		stop_recovery_and_watchdog_i (
		.sys_clk_i(sys_clk), .rstn_i(rstn), .apb_req_i(req), .apb_rsp_o(rsp),
		.xtal_i(osc_cnt[2]), .rcosc_i(osc_cnt[3]), .supply_ok_i(supply_ok),
		.rec_src_i(rec_src), .spi_compare_i(1'b0), .wdt_exec_i(wdt_exec),
		.halt_req_i(halt_req), .stop_req_i(stop_req), .wake_i(wake),
		.sclk_tick_o(sclk_tick), .timer_clock_tick_o(timer_clock_tick), .core_rst_o(core_rst),
		.restart_vector_o(), .flag_we_o(flag_we), .flags_zsv_o(), .pwr_state_o(state));

	// Clock; crystal at 1/8 and RC at 1/16 keep clear of the synchroniser limit
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
		osc_cnt <= osc_cnt + 4'h1;

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_in(input int v, input int lo, input int hi);
		check(32'(v), (v >= lo && v <= hi) ? 32'(v) : 32'(lo));
	endtask

	// One APB transfer; answer taken at the edge that sees pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge sys_clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			k++;
		end
		while (rsp.pready !== 1'b1 && k < 16);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		if (k >= 16)
		begin
			err_count++;
			tally_and_finish();
		end
	endtask

	task automatic pulse(input logic stop);
		@(posedge sys_clk);
		stop_req <= stop;
		wdt_exec <= !stop;
		@(posedge sys_clk);
		stop_req <= 1'b0;
		wdt_exec <= 1'b0;
	endtask

	task automatic wait_rst(input logic lvl, input int bound, output int c);
		c = 0;
		while (core_rst !== lvl && c < bound)
		begin
			@(negedge sys_clk);
			c++;
		end
		if (core_rst !== lvl)
		begin
			err_count++;
			tally_and_finish();
		end
	endtask

	// Ticks sampled mid-cycle, where registered outputs have settled
	task automatic count(input int cyc, output int sc, output int tc);
		sc = 0;
		tc = 0;
		repeat (cyc)
		begin
			@(negedge sys_clk);
			if (sclk_tick === 1'b1) sc++;
			if (timer_clock_tick === 1'b1) tc++;
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_map();
		// Power-on reports supply as cause: its synchroniser starts low
		apb(1'b0, A_STAT, 32'h0000_0000);
		check(rd, 32'h0000_0091);
		apb(1'b0, 12'h100, 32'h0000_0000);
		check(32'(err), 32'h0000_0001);
		apb(1'b1, A_REC, 32'h0000_00C0);
		apb(1'b0, A_REC, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(1'b0, A_MODE, 32'h0000_0000);
		check(rd, 32'h0000_0000);
	endtask

	// Tap 256 on RC, then a late write for tap 4096 must be lost
	task automatic t_wdt();
		apb(1'b1, A_MODE, 32'h0000_000C);
		count(1200, s, t);
		apb(1'b0, A_STAT, 32'h0000_0000);
		check(32'(rd[4]), 32'h0000_0000);
		apb(1'b1, A_MODE, 32'h0000_0003);
		pulse(1'b0);
		@(negedge sys_clk);
		check(32'(flag_we), 32'h0000_0001);
		count(2000, s, t);
		check(32'(core_rst), 32'h0000_0000);
		pulse(1'b0);
		wait_rst(1'b1, 6000, n);
		check_in(n, 4056, 4136);
		wait_rst(1'b0, 100, n);
		apb(1'b0, A_STAT, 32'h0000_0000);
		check(rd, 32'h0000_0119);
	endtask

	task automatic t_clock();
		pulse(1'b0);
		count(160, s, t);
		check_in(s, 9, 11);
		check_in(t, s - 1, s + 1);
		apb(1'b1, A_REC, 32'h0000_0002);
		count(160, s, t);
		check_in(s, 19, 21);
		apb(1'b1, A_REC, 32'h0000_0003);
		count(640, s, t);
		check_in(s, 4, 6);
		apb(1'b1, A_REC, 32'h0000_0000);
	endtask

	// HALT stops the system clock only; wake returns to RUN
	task automatic t_halt();
		@(posedge sys_clk);
		halt_req <= 1'b1;
		@(posedge sys_clk);
		halt_req <= 1'b0;
		@(posedge sys_clk);
		count(160, s, t);
		check(32'(state), 32'(PWR_HALT));
		check_in(s, 0, 0);
		check_in(t, 9, 11);
		@(posedge sys_clk);
		wake <= 1'b1;
		@(posedge sys_clk);
		wake <= 1'b0;
		count(20, s, t);
		check(32'(state), 32'(PWR_RUN));
		check_in(s, 1, 2);
	endtask

	// High level on source 2 with delay, then low level without
	task automatic t_rec();
		pulse(1'b0);
		apb(1'b1, A_REC, 32'h0000_0068);
		pulse(1'b1);
		rec_src <= 8'h02;
		count(20, s, t);
		check(32'(state), 32'(PWR_STOP));
		check_in(s, 0, 0);
		@(posedge sys_clk);
		rec_src <= 8'h06;
		wait_rst(1'b1, 20, n);
		wait_rst(1'b0, 40, n);
		check_in(n, 8, 10);
		apb(1'b0, A_REC, 32'h0000_0000);
		check(rd, 32'h0000_0080);
		apb(1'b1, A_REC, 32'h0000_0008);
		pulse(1'b1);
		count(20, s, t);
		check(32'(state), 32'(PWR_STOP));
		@(posedge sys_clk);
		rec_src <= 8'h00;
		wait_rst(1'b1, 20, n);
		wait_rst(1'b0, 20, n);
		check_in(n, 1, 3);
	endtask

	task automatic t_supply();
		@(posedge sys_clk);
		supply_ok <= 1'b0;
		wait_rst(1'b1, 10, n);
		count(40, s, t);
		check(32'(core_rst), 32'h0000_0001);
		@(posedge sys_clk);
		supply_ok <= 1'b1;
		wait_rst(1'b0, 40, n);
		check_in(n, 9, 14);
	endtask

	// Main sequence
	initial
	begin
		rstn = 1'b0;
		req = '0;
		supply_ok = 1'b1;
		rec_src = 8'h00;
		wdt_exec = 1'b0;
		stop_req = 1'b0;
		halt_req = 1'b0;
		wake = 1'b0;
		err_count = 0;
		check_count = 0;
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		wait_rst(1'b0, 100, n);
		t_map();
		t_wdt();
		t_clock();
		t_halt();
		t_rec();
		t_supply();
		tally_and_finish();
	end
endmodule

`default_nettype wire

// file: sim/stop_wdt_props.sv
// Port checker for the stop recovery and watchdog block
`timescale 1ns/1ps
`default_nettype none

module stop_wdt_props
	import stop_wdt_pkg::*;
(
	input wire logic                   sys_clk_i,
	input wire logic                   rstn_i,
	input wire stop_wdt_pkg::apb_req_t apb_req_i,
	input wire stop_wdt_pkg::apb_rsp_t apb_rsp_o,
	input wire logic                   supply_ok_i,
	input wire logic                   wdt_exec_i,
	input wire logic                   core_rst_o,
	input wire logic [15:0]            restart_vector_o,
	input wire logic                   flag_we_o,
	input wire logic [2:0]             flags_zsv_o,
	input wire logic [2:0]             pwr_state_o
);
	// ------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------
	logic acc;
	logic mapped;
	assign acc = apb_req_i.psel && apb_req_i.penable;
	assign mapped = apb_req_i.paddr inside {12'h02C, 12'h03C, 12'h040, 12'h044};

	// One clock domain, power-on reset disables all
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	vector_fixed_a: assert property (restart_vector_o == 16'h000C)
		else $error("restart vector differs");
	supply_hold_a: assert property ((!supply_ok_i) [*4] |-> core_rst_o)
		else $error("reset released under low supply");
	rst_min_a: assert property ($rose(core_rst_o) |=> core_rst_o)
		else $error("device reset too short");
	stop_exit_a: assert property (
		pwr_state_o == PWR_STOP |=> pwr_state_o == PWR_STOP || core_rst_o)
		else $error("stop left without reset");
	refresh_flag_a: assert property (
		wdt_exec_i && !core_rst_o && pwr_state_o == PWR_RUN |=> flag_we_o)
		else $error("refresh gave no flag write");
	flags_val_a: assert property (flag_we_o |-> flags_zsv_o == 3'h0)
		else $error("flag value wrong");
	rec_read_a: assert property (
		acc && !apb_req_i.pwrite && apb_req_i.paddr == 12'h02C
		|-> (apb_rsp_o.prdata & 32'hFFFF_FF7F) == 32'h0000_0000)
		else $error("write-only recovery bits readable");
	mode_read_a: assert property (
		acc && !apb_req_i.pwrite && apb_req_i.paddr == 12'h03C
		|-> apb_rsp_o.prdata == 32'h0000_0000)
		else $error("mode register readable");
	unmapped_err_a: assert property (acc && !mapped |-> apb_rsp_o.pslverr)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (
		acc && mapped |-> apb_rsp_o.pready && !apb_rsp_o.pslverr)
		else $error("mapped access refused");
endmodule

bind stop_recovery_and_watchdog stop_wdt_props stop_wdt_props_i (
	.sys_clk_i        (sys_clk_i),
	.rstn_i           (rstn_i),
	.apb_req_i        (apb_req_i),
	.apb_rsp_o        (apb_rsp_o),
	.supply_ok_i      (supply_ok_i),
	.wdt_exec_i       (wdt_exec_i),
	.core_rst_o       (core_rst_o),
	.restart_vector_o (restart_vector_o),
	.flag_we_o        (flag_we_o),
	.flags_zsv_o      (flags_zsv_o),
	.pwr_state_o      (pwr_state_o)
);

`default_nettype wire
